/* verilog/ipc_pkg.sv */
package ipc_pkg;
    // Register addresses
    localparam logic [15:0] SYSCTL_ADDR = 16'hfff2;
    localparam logic [15:0] SENSE_ADDR = 16'hfff4;
    localparam logic [15:0] ENABLE_ADDR = 16'hfff5;
    localparam logic [15:0] FLAGS_ADDR = 16'hfff6;
    localparam logic [15:0] PRIO_A_ADDR = 16'hfff8;
    localparam logic [15:0] PRIO_B_ADDR = 16'hfff9;
    // Reset values
    localparam logic [7:0] SYSCTL_RST = 8'h0b;
    localparam logic [7:0] SENSE_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] PRIO_A_RST = 8'h00;
    localparam logic [7:0] PRIO_B_RST = 8'h00;
    localparam logic [7:0] FLAGS_MASK = 8'h3f;
    // System control fields
    localparam int USER_FLAG_ROLE_BIT = 3;
    localparam int NMI_EDGE_BIT = 2;
    // Priority select A fields
    localparam int PRIO_EXT_REQ0 = 7;
    localparam int PRIO_EXT_REQ1 = 6;
    localparam int PRIO_EXT_REQ2_3 = 5;
    localparam int PRIO_EXT_REQ4_5 = 4;
    localparam int PRIO_WATCHDOG_REFRESH = 3;
    localparam int PRIO_TIMER_CH0 = 2;
    localparam int PRIO_TIMER_CH1 = 1;
    localparam int PRIO_TIMER_CH2 = 0;
    // Priority select B fields
    localparam int PRIO_TIMER_CH3 = 7;
    localparam int PRIO_TIMER_CH4 = 6;
    // Source numbering: external 0..5, watchdog/refresh 6, timers 7..11
    localparam int N_EXT = 6;
    localparam int N_INT = 6;
    localparam int N_SRC = 12;
    // Vector numbers
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_EXT_BASE = 8'h0c;
    localparam logic [7:0] VEC_INT_BASE = 8'h14;
    localparam logic [7:0] VEC_INT_OFS = 8'h0e;
endpackage : ipc_pkg

/* verilog/ipc_ext_channel.sv */
`timescale 1ns/1ps
module ipc_ext_channel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hw_standby_i,
    input wire logic pin_n_i,
    input wire logic ext_req_sense_i,
    input wire logic flags_rd_i,
    input wire logic flags_wr_i,
    input wire logic wdata_bit_i,
    input wire logic service_i,
    output logic ext_req_flag_o
);
    logic pin_q;
    logic flag_q;
    logic armed_q;
    logic set_ev;
    logic sw_clr;
    logic svc_clr;

    // Falling edge or low level
    assign set_ev = ext_req_sense_i ? (pin_q & ~pin_n_i) : ~pin_n_i;
    assign sw_clr = flags_wr_i & ~wdata_bit_i & armed_q;
    assign svc_clr = service_i & (ext_req_sense_i | pin_n_i);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= pin_n_i;
        end
    end

    // Armed by a read that saw the flag set
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else if (hw_standby_i || flags_wr_i || !flag_q) begin
            armed_q <= 1'b0;
        end else if (flags_rd_i) begin
            armed_q <= 1'b1;
        end
    end

    // Set wins over clear; writing 1 never sets
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (hw_standby_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= set_ev | (flag_q & ~(sw_clr | svc_clr));
        end
    end

    assign ext_req_flag_o = flag_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || hw_standby_i);

    level_set_a: assert property (!ext_req_sense_i && !pin_n_i |=> flag_q)
        else $error("level request did not set flag");
    edge_set_a: assert property (ext_req_sense_i && pin_q && !pin_n_i |=> flag_q)
        else $error("falling edge did not set flag");
    no_write_set_a: assert property (!flag_q && !set_ev |=> !flag_q)
        else $error("flag set without a request");
endmodule : ipc_ext_channel

/* verilog/ipc_top.sv */
`timescale 1ns/1ps
module ipc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hw_standby_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic nmi_i,
    input wire logic [5:0] ext_req_pins_n_i,
    input wire logic [5:0] periph_req_i,
    input wire logic cpu_main_mask_i,
    input wire logic user_mask_flag_i,
    input wire logic cpu_ack_i,
    output logic irq_req_o,
    output logic [7:0] irq_vector_o,
    output logic irq_level_o,
    output logic [5:0] periph_ack_o
);
    logic [7:0] system_control_q;
    logic [7:0] sense_q;
    logic [7:0] enable_q;
    logic [7:0] prio_a_q;
    logic [7:0] prio_b_q;
    logic [7:0] rdata_q;
    logic [5:0] flags;
    logic [5:0] svc_ext;
    logic nmi_q;
    logic nmi_pend_q;
    logic nmi_edge;
    logic nmi_sel_q;
    logic req_q;
    logic level_q;
    logic [3:0] idx_q;
    logic [7:0] vec_q;
    logic [5:0] periph_ack_q;
    logic [11:0] pend;
    logic [11:0] lvl;
    logic [11:0] hi;
    logic [11:0] lo;
    logic ok_lo;
    logic ok_hi;
    logic any_req;
    logic [3:0] sel_idx;
    logic take;
    logic wr_flags;
    logic rd_flags;

    // Level bit for one maskable source
    function automatic logic prio_of(input int idx, input logic [7:0] pa,
                                     input logic [7:0] pb);
        logic r;
        r = 1'b0;
        case (idx)
            0: r = pa[ipc_pkg::PRIO_EXT_REQ0];
            1: r = pa[ipc_pkg::PRIO_EXT_REQ1];
            2, 3: r = pa[ipc_pkg::PRIO_EXT_REQ2_3];
            4, 5: r = pa[ipc_pkg::PRIO_EXT_REQ4_5];
            6: r = pa[ipc_pkg::PRIO_WATCHDOG_REFRESH];
            7: r = pa[ipc_pkg::PRIO_TIMER_CH0];
            8: r = pa[ipc_pkg::PRIO_TIMER_CH1];
            9: r = pa[ipc_pkg::PRIO_TIMER_CH2];
            10: r = pb[ipc_pkg::PRIO_TIMER_CH3];
            11: r = pb[ipc_pkg::PRIO_TIMER_CH4];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : prio_of

    // Lowest pending index wins
    function automatic logic [3:0] first_idx(input logic [11:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = ipc_pkg::N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : first_idx

    // Register writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            system_control_q <= ipc_pkg::SYSCTL_RST;
            sense_q <= ipc_pkg::SENSE_RST;
            enable_q <= ipc_pkg::ENABLE_RST;
            prio_a_q <= ipc_pkg::PRIO_A_RST;
            prio_b_q <= ipc_pkg::PRIO_B_RST;
        end else if (hw_standby_i) begin
            system_control_q <= ipc_pkg::SYSCTL_RST;
            sense_q <= ipc_pkg::SENSE_RST;
            enable_q <= ipc_pkg::ENABLE_RST;
            prio_a_q <= ipc_pkg::PRIO_A_RST;
            prio_b_q <= ipc_pkg::PRIO_B_RST;
        end else if (wr_i) begin
            case (addr_i)
                ipc_pkg::SYSCTL_ADDR: system_control_q <= wdata_i;
                ipc_pkg::SENSE_ADDR: sense_q <= wdata_i;
                ipc_pkg::ENABLE_ADDR: enable_q <= wdata_i;
                ipc_pkg::PRIO_A_ADDR: prio_a_q <= wdata_i;
                ipc_pkg::PRIO_B_ADDR: prio_b_q <= wdata_i;
                default: ;
            endcase
        end
    end

    // Register reads, data valid one cycle later only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ipc_pkg::SYSCTL_ADDR: rdata_q <= system_control_q;
                ipc_pkg::SENSE_ADDR: rdata_q <= sense_q;
                ipc_pkg::ENABLE_ADDR: rdata_q <= enable_q;
                ipc_pkg::FLAGS_ADDR: rdata_q <= {2'b00, flags};
                ipc_pkg::PRIO_A_ADDR: rdata_q <= prio_a_q;
                ipc_pkg::PRIO_B_ADDR: rdata_q <= prio_b_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o = rdata_q;
    assign wr_flags = wr_i && (addr_i == ipc_pkg::FLAGS_ADDR);
    assign rd_flags = rd_i && (addr_i == ipc_pkg::FLAGS_ADDR);

    // External request channels
    for (genvar n = 0; n < ipc_pkg::N_EXT; n++) begin : g_ext
        ipc_ext_channel u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .hw_standby_i(hw_standby_i),
            .pin_n_i(ext_req_pins_n_i[n]),
            .ext_req_sense_i(sense_q[n]),
            .flags_rd_i(rd_flags),
            .flags_wr_i(wr_flags),
            .wdata_bit_i(wdata_i[n]),
            .service_i(svc_ext[n]),
            .ext_req_flag_o(flags[n])
        );
        assign svc_ext[n] = take && (idx_q == 4'(n));
    end

    // Nonmaskable edge detect
    assign nmi_edge = system_control_q[ipc_pkg::NMI_EDGE_BIT] ?
                      (~nmi_q & nmi_i) : (nmi_q & ~nmi_i);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= nmi_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_pend_q <= 1'b0;
        end else if (hw_standby_i) begin
            nmi_pend_q <= 1'b0;
        end else begin
            nmi_pend_q <= nmi_edge | (nmi_pend_q & ~(cpu_ack_i & req_q & nmi_sel_q));
        end
    end

    // Pending and level per maskable source
    assign pend = {periph_req_i, flags & enable_q[5:0]};
    for (genvar s = 0; s < ipc_pkg::N_SRC; s++) begin : g_lvl
        assign lvl[s] = prio_of(s, prio_a_q, prio_b_q);
    end

    // Three-level masking
    assign ok_lo = ~cpu_main_mask_i;
    assign ok_hi = system_control_q[ipc_pkg::USER_FLAG_ROLE_BIT] ?
                   ~cpu_main_mask_i : ~user_mask_flag_i;
    assign hi = pend & lvl & {ipc_pkg::N_SRC{ok_hi}};
    assign lo = pend & ~lvl & {ipc_pkg::N_SRC{ok_lo}};
    assign any_req = |hi || |lo;
    assign sel_idx = (|hi) ? first_idx(hi) : first_idx(lo);
    assign take = cpu_ack_i && req_q && !nmi_sel_q;

    // Presented request to the CPU
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q <= 1'b0;
            nmi_sel_q <= 1'b0;
            level_q <= 1'b0;
            idx_q <= 4'h0;
        end else begin
            req_q <= ~cpu_ack_i & ~hw_standby_i & (nmi_pend_q | any_req);
            nmi_sel_q <= nmi_pend_q;
            level_q <= nmi_pend_q | (|hi);
            idx_q <= sel_idx;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vec_q <= 8'h00;
        end else if (nmi_pend_q) begin
            vec_q <= ipc_pkg::VEC_NMI;
        end else if (sel_idx < 4'(ipc_pkg::N_EXT)) begin
            vec_q <= ipc_pkg::VEC_EXT_BASE + {4'h0, sel_idx};
        end else begin
            vec_q <= ipc_pkg::VEC_INT_OFS + {4'h0, sel_idx};
        end
    end

    // Service pulse to on-chip sources
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            periph_ack_q <= 6'h00;
        end else begin
            for (int k = 0; k < ipc_pkg::N_INT; k++) begin
                periph_ack_q[k] <= take && (idx_q == 4'(k + ipc_pkg::N_EXT));
            end
        end
    end

    assign irq_req_o = req_q;
    assign irq_vector_o = vec_q;
    assign irq_level_o = level_q;
    assign periph_ack_o = periph_ack_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence nmi_raised_s;
        nmi_pend_q && !cpu_ack_i && !hw_standby_i;
    endsequence

    sequence nmi_shown_s;
        req_q && vec_q == ipc_pkg::VEC_NMI;
    endsequence

    nmi_wins_a: assert property (nmi_raised_s |=> nmi_shown_s)
        else $error("nonmaskable request not presented");
    nmi_edge_a: assert property (!hw_standby_i && system_control_q[2] && !nmi_q && nmi_i
                                 |=> nmi_pend_q)
        else $error("rising nonmaskable edge lost");
    standby_init_a: assert property (hw_standby_i |=> system_control_q == 8'h0b
                                     && prio_a_q == 8'h00 && prio_b_q == 8'h00)
        else $error("standby did not initialise registers");
    high_first_a: assert property (|hi && !nmi_pend_q && !cpu_ack_i && !hw_standby_i
                                   |=> req_q && irq_level_o)
        else $error("level 0 presented over level 1");
    main_mask_a: assert property (cpu_main_mask_i && system_control_q[3] && !nmi_pend_q
                                  |=> !req_q)
        else $error("masked request presented");
    user_mask_a: assert property (!cpu_main_mask_i && !system_control_q[3]
                                  && ((pend & ~lvl) != 12'h000
                                  || (!user_mask_flag_i && pend != 12'h000))
                                  && !cpu_ack_i && !hw_standby_i
                                  |=> req_q)
        else $error("unmasked request not presented");
    ext_vec_a: assert property (req_q && !nmi_sel_q && idx_q == 4'h2
                                |-> vec_q == 8'h0e)
        else $error("wrong vector for request 2");
    enable_gate_a: assert property (req_q && !nmi_sel_q && idx_q == 4'h0
                                    |-> $past(enable_q[0]))
        else $error("disabled request presented");
    read_back_a: assert property (rd_i && addr_i == 16'hfff8
                                  |=> rdata_o == $past(prio_a_q))
        else $error("priority register read wrong");

    // Nonmaskable accept, request withdrawal, falling nonmaskable edge and standby checks
    sequence nmi_taken_s;
        cpu_ack_i && req_q && nmi_sel_q && !nmi_edge;
    endsequence

    nmi_clear_a: assert property (nmi_taken_s
                                  |=> !nmi_pend_q)
        else $error("accepted nonmaskable request still pending");
    ack_drop_a: assert property (cpu_ack_i && req_q
                                 |=> !req_q)
        else $error("request not withdrawn after accept");
    nmi_fall_a: assert property (!hw_standby_i && !system_control_q[ipc_pkg::NMI_EDGE_BIT]
                                 && nmi_q && !nmi_i |=> nmi_pend_q)
        else $error("falling nonmaskable edge lost");
    sby_clear_a: assert property (hw_standby_i
                                  |=> !req_q && sense_q == ipc_pkg::SENSE_RST
                                  && enable_q == ipc_pkg::ENABLE_RST)
        else $error("standby did not clear request or controls");

    // Register writes land, read data checks
    sysctl_write_a: assert property (wr_i && addr_i == ipc_pkg::SYSCTL_ADDR && !hw_standby_i
                                     |=> system_control_q == $past(wdata_i))
        else $error("system control write lost");
    sense_write_a: assert property (wr_i && addr_i == ipc_pkg::SENSE_ADDR && !hw_standby_i
                                    |=> sense_q == $past(wdata_i))
        else $error("sense select write lost");
    enable_write_a: assert property (wr_i && addr_i == ipc_pkg::ENABLE_ADDR && !hw_standby_i
                                     |=> enable_q == $past(wdata_i))
        else $error("enable write lost");
    prio_a_write_a: assert property (wr_i && addr_i == ipc_pkg::PRIO_A_ADDR && !hw_standby_i
                                     |=> prio_a_q == $past(wdata_i))
        else $error("priority A write lost");
    prio_b_write_a: assert property (wr_i && addr_i == ipc_pkg::PRIO_B_ADDR && !hw_standby_i
                                     |=> prio_b_q == $past(wdata_i))
        else $error("priority B write lost");
    flags_read_a: assert property (rd_i && addr_i == ipc_pkg::FLAGS_ADDR
                                   |=> rdata_o == {2'b00, $past(flags)})
        else $error("flag register read wrong");
    rd_idle_a: assert property (!rd_i
                                |=> rdata_o == 8'h00)
        else $error("read data without a read");

    // Masking, vectors and service
    lo_block_a: assert property (!system_control_q[3] && cpu_main_mask_i
                                 && user_mask_flag_i && !nmi_pend_q |=> !req_q)
        else $error("request passed both masks");
    hi_block_a: assert property (!system_control_q[3] && !cpu_main_mask_i && user_mask_flag_i
                                 && (pend & ~lvl) == 12'h000 && !nmi_pend_q |=> !req_q)
        else $error("level 1 request passed user mask");
    int_vec_a: assert property (req_q && !nmi_sel_q && idx_q == 4'h7
                                |-> vec_q == 8'h15)
        else $error("wrong vector for timer channel 0");
    periph_ack_a: assert property (cpu_ack_i && req_q && !nmi_sel_q && idx_q == 4'h6
                                   |=> periph_ack_o == 6'h01)
        else $error("service pulse missing");
    ack_pulse_a: assert property (periph_ack_o != 6'h00
                                  |=> periph_ack_o == 6'h00)
        else $error("service pulse longer than one cycle");
endmodule : ipc_top

/* sim/ipc_cpu_model.sv */
`timescale 1ns/1ps
module ipc_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_req_i,
    input wire logic [7:0] irq_vector_i,
    input wire logic ack_en_i,
    input wire logic [3:0] delay_i,
    output logic cpu_ack_o,
    output logic [7:0] last_vec_o
);
    logic [3:0] wait_q;
    // Accepts after delay_i waiting cycles, one pulse per accept
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_ack_o <= 1'b0;
            wait_q <= 4'h0;
            last_vec_o <= 8'h00;
        end else if (cpu_ack_o || !irq_req_i || !ack_en_i) begin
            cpu_ack_o <= 1'b0;
            wait_q <= 4'h0;
        end else if (wait_q == delay_i) begin
            cpu_ack_o <= 1'b1;
            last_vec_o <= irq_vector_i;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : ipc_cpu_model

/* sim/interrupt_priority_control_bench.sv */
`timescale 1ns/1ps
module interrupt_priority_control_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_standby_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic nmi_i = 1'b0;
    logic [5:0] ext_req_pins_n_i = 6'h3f;
    logic [5:0] periph_req_i = 6'h00;
    logic cpu_main_mask_i = 1'b0;
    logic user_mask_flag_i = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_delay = 4'h0;
    logic cpu_ack;
    logic [7:0] rdata_o;
    logic [7:0] irq_vector_o;
    logic [7:0] last_vec;
    logic irq_req_o;
    logic irq_level_o;
    logic [5:0] periph_ack_o;
    logic [5:0] seen;
    int num_errors = 0;
    int cmp_count = 0;

    always #25 clk_i = ~clk_i;

    ipc_top dut (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nmi_i(nmi_i),
        .ext_req_pins_n_i(ext_req_pins_n_i), .periph_req_i(periph_req_i),
        .cpu_main_mask_i(cpu_main_mask_i), .user_mask_flag_i(user_mask_flag_i),
        .cpu_ack_i(cpu_ack), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
        .irq_level_o(irq_level_o), .periph_ack_o(periph_ack_o));
    ipc_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
        .irq_vector_i(irq_vector_o), .ack_en_i(ack_en), .delay_i(ack_delay),
        .cpu_ack_o(cpu_ack), .last_vec_o(last_vec));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask : rd_chk

    task automatic req_chk(input string what, input logic r, input logic [7:0] v, input logic l);
        repeat (3) @(posedge clk_i);
        #1;
        chk({what, " req"}, {7'h00, r}, {7'h00, irq_req_o});
        if (r) begin
            chk({what, " vec"}, v, irq_vector_o);
            chk({what, " lvl"}, {7'h00, l}, {7'h00, irq_level_o});
        end
    endtask : req_chk

    task automatic accept(input string what, input logic [7:0] v);
        ack_en <= 1'b1;
        repeat (8) @(posedge clk_i);
        ack_en <= 1'b0;
        chk(what, v, last_vec);
    endtask : accept

    task automatic t_reset;
        rd_chk("sysctl", ipc_pkg::SYSCTL_ADDR, 8'h0b);
        rd_chk("sense", ipc_pkg::SENSE_ADDR, 8'h00);
        rd_chk("enable", ipc_pkg::ENABLE_ADDR, 8'h00);
        rd_chk("prio a", ipc_pkg::PRIO_A_ADDR, 8'h00);
        rd_chk("prio b", ipc_pkg::PRIO_B_ADDR, 8'h00);
        rd_chk("unmapped", 16'hfff3, 8'h00);
        wr(ipc_pkg::FLAGS_ADDR, 8'hff);
        rd_chk("flags set", ipc_pkg::FLAGS_ADDR, 8'h00);
    endtask : t_reset

    task automatic t_ext;
        @(posedge clk_i);
        ext_req_pins_n_i[0] <= 1'b0;
        req_chk("ext0 off", 1'b0, 8'h00, 1'b0);
        wr(ipc_pkg::ENABLE_ADDR, 8'h01);
        req_chk("ext0", 1'b1, 8'h0c, 1'b0);
        rd_chk("flag0", ipc_pkg::FLAGS_ADDR, 8'h01);
        ext_req_pins_n_i[0] <= 1'b1;
        accept("ext0 ack", 8'h0c);
        rd_chk("flag0 clr", ipc_pkg::FLAGS_ADDR, 8'h00);
        wr(ipc_pkg::PRIO_A_ADDR, 8'h40);
        wr(ipc_pkg::SENSE_ADDR, 8'h02);
        wr(ipc_pkg::ENABLE_ADDR, 8'h02);
        ext_req_pins_n_i[1] <= 1'b0;
        @(posedge clk_i);
        ext_req_pins_n_i[1] <= 1'b1;
        req_chk("ext1 edge", 1'b1, 8'h0d, 1'b1);
        rd_chk("flag1", ipc_pkg::FLAGS_ADDR, 8'h02);
        wr(ipc_pkg::FLAGS_ADDR, 8'h00);
        rd_chk("flag1 clr", ipc_pkg::FLAGS_ADDR, 8'h00);
        req_chk("ext1 gone", 1'b0, 8'h00, 1'b0);
        wr(ipc_pkg::ENABLE_ADDR, 8'h00);
        wr(ipc_pkg::PRIO_A_ADDR, 8'h00);
    endtask : t_ext

    task automatic t_prio;
        logic [29:0] tab [6] = '{{8'h00, 8'h00, 6'h03, 8'h14}, {8'h04, 8'h00, 6'h03, 8'h15},
            {8'h0c, 8'h00, 6'h03, 8'h14}, {8'h00, 8'h80, 6'h11, 8'h18},
            {8'h00, 8'h40, 6'h21, 8'h19}, {8'h02, 8'h00, 6'h05, 8'h16}};
        for (int i = 0; i < 6; i++) begin
            wr(ipc_pkg::PRIO_A_ADDR, tab[i][29:22]);
            wr(ipc_pkg::PRIO_B_ADDR, tab[i][21:14]);
            periph_req_i <= tab[i][13:8];
            req_chk("prio", 1'b1, tab[i][7:0], i != 0);
        end
        periph_req_i <= 6'h04;
        ack_delay <= 4'h3;
        ack_en <= 1'b1;
        seen = 6'h00;
        repeat (10) begin
            @(posedge clk_i);
            #1;
            seen = seen | periph_ack_o;
        end
        ack_en <= 1'b0;
        periph_req_i <= 6'h00;
        chk("periph ack", 8'h04, {2'b00, seen});
    endtask : t_prio

    task automatic t_mask;
        logic [17:0] tab [6] = '{{8'h0b, 2'b10, 8'h00}, {8'h0b, 2'b01, 8'h15},
            {8'h03, 2'b10, 8'h15}, {8'h03, 2'b11, 8'h00}, {8'h03, 2'b01, 8'h14},
            {8'h03, 2'b00, 8'h15}};
        wr(ipc_pkg::PRIO_A_ADDR, 8'h04);
        wr(ipc_pkg::PRIO_B_ADDR, 8'h00);
        periph_req_i <= 6'h03;
        for (int i = 0; i < 6; i++) begin
            wr(ipc_pkg::SYSCTL_ADDR, tab[i][17:10]);
            cpu_main_mask_i <= tab[i][9];
            user_mask_flag_i <= tab[i][8];
            req_chk("mask", tab[i][7:0] != 8'h00, tab[i][7:0], tab[i][0]);
        end
    endtask : t_mask

    task automatic t_nmi;
        periph_req_i <= 6'h00;
        cpu_main_mask_i <= 1'b1;
        user_mask_flag_i <= 1'b1;
        nmi_i <= 1'b1;
        req_chk("nmi rise", 1'b0, 8'h00, 1'b0);
        nmi_i <= 1'b0;
        req_chk("nmi fall", 1'b1, ipc_pkg::VEC_NMI, 1'b1);
        accept("nmi ack", ipc_pkg::VEC_NMI);
        cpu_main_mask_i <= 1'b0;
        user_mask_flag_i <= 1'b0;
        periph_req_i <= 6'h01;
        wr(ipc_pkg::SYSCTL_ADDR, 8'h07);
        nmi_i <= 1'b1;
        req_chk("nmi first", 1'b1, ipc_pkg::VEC_NMI, 1'b1);
        ack_delay <= 4'h0;
        ack_en <= 1'b1;
        @(posedge clk_i);
        ack_en <= 1'b0;
        req_chk("after nmi", 1'b1, 8'h14, 1'b0);
        periph_req_i <= 6'h00;
    endtask : t_nmi

    task automatic t_standby;
        wr(ipc_pkg::PRIO_A_ADDR, 8'hff);
        wr(ipc_pkg::PRIO_B_ADDR, 8'hc0);
        wr(ipc_pkg::ENABLE_ADDR, 8'h3f);
        @(posedge clk_i);
        hw_standby_i <= 1'b1;
        @(posedge clk_i);
        hw_standby_i <= 1'b0;
        rd_chk("sby sysctl", ipc_pkg::SYSCTL_ADDR, 8'h0b);
        rd_chk("sby prio a", ipc_pkg::PRIO_A_ADDR, 8'h00);
        rd_chk("sby prio b", ipc_pkg::PRIO_B_ADDR, 8'h00);
        rd_chk("sby enable", ipc_pkg::ENABLE_ADDR, 8'h00);
    endtask : t_standby

    task automatic test_done;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ext();
        t_prio();
        t_mask();
        t_nmi();
        t_standby();
        test_done();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        test_done();
    end
endmodule : interrupt_priority_control_bench
